/* pt_pkg.sv */
// constants, types and state codes for the pass-through port and its add-on end
// assumes one 10 MHz clock shared by the bus side and the add-on side
package pt_pkg;
    localparam int          NREG           = 4;
    localparam logic [31:0] REGION_BASE [NREG] = '{32'h1000_0000, 32'h1000_1000,
                                                   32'h1000_2000, 32'h1000_3000};
    localparam logic [31:0] REGION_MASK [NREG] = '{32'h0000_0fff, 32'h0000_0fff,
                                                   32'h0000_0fff, 32'h0000_0fff};
    localparam logic [31:0] OPREG_BASE     = 32'h2000_0000;
    localparam logic [31:0] OPREG_MASK     = 32'h0000_003f;
    localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;
    localparam logic [4:0]  FIRST_WAIT     = 5'h10;
    localparam logic [4:0]  NEXT_WAIT      = 5'h08;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_WIDTH     = 64;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_WDATA = 6'h02,
        ST_RDATA = 6'h04,
        ST_STOP  = 6'h08,
        ST_TURN  = 6'h10,
        ST_OPREG = 6'h20
    } tgt_state_e;

    typedef enum logic [2:0] {
        AS_IDLE  = 3'h1,
        AS_WRITE = 3'h2,
        AS_DONE  = 3'h4
    } addon_state_e;

    // all fields reset to zero; active-low pins are inverted at the ports
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] ad;
        logic [1:0]  region;
        logic [3:0]  lanes;
        logic [4:0]  cnt;
        logic        wr_dir;
        logic        pend;
        logic        burst;
        logic        rd_avail;
        logic        first;
        logic        op_read;
        logic        ad_oe;
        logic        devsel;
        logic        trdy;
        logic        stop;
        logic        frame_act;
    } tgt_regs_s;
endpackage

/* pt_link_if.sv */
// add-on link between the pass-through port and the add-on logic
// assumes both ends run on the same clock
interface pt_link_if;
    logic        access_pending_n;
    logic        burst_flag_n;
    logic [1:0]  region_index;
    logic [3:0]  lane_enables_n;
    logic        write_direction;
    logic [31:0] passthru_address_reg;
    logic [31:0] passthru_data_reg;
    logic        addon_wr_en;
    logic [31:0] addon_wr_data;
    logic        addon_done_n;

    modport device (
        output access_pending_n, burst_flag_n, region_index, lane_enables_n,
        output write_direction, passthru_address_reg, passthru_data_reg,
        input  addon_wr_en, addon_wr_data, addon_done_n
    );
    modport addon (
        input  access_pending_n, burst_flag_n, region_index, lane_enables_n,
        input  write_direction, passthru_address_reg, passthru_data_reg,
        output addon_wr_en, addon_wr_data, addon_done_n
    );
endinterface

/* pt_port.sv */
// pass-through target port: bus target on one side, add-on link on the other
// assumes bus pins already synchronous to i_clock; pin tristating done outside
module pt_port (
    input  wire logic        i_clock,    // bus clock
    input  wire logic        i_rstn,     // async reset, active low
    input  wire logic        i_frame_n,  // frame from initiator
    input  wire logic        i_irdy_n,   // initiator ready
    input  wire logic [31:0] i_ad,       // address/data bus in
    input  wire logic [3:0]  i_cbe_n,    // command / byte enables
    output logic      [31:0] o_ad,       // read data out
    output logic             o_ad_oe,    // drive ad bus
    output logic             o_devsel_n, // device select
    output logic             o_trdy_n,   // target ready
    output logic             o_stop_n,   // stop (retry/disconnect)
    output logic             o_tgt_oe,   // drive devsel/trdy/stop
    pt_link_if.device        link        // add-on link
);
    import pt_pkg::*;

    tgt_regs_s   r;
    tgt_regs_s   n;
    tgt_state_e  state;
    tgt_state_e  next_state;
    logic        pt_hit;
    logic [1:0]  hit_idx;
    logic        op_hit;
    logic        rd_busy;
    logic [4:0]  limit;
    logic [31:0] addr_inc;

    function automatic logic in_region(input logic [31:0] a, input logic [1:0] i);
        return (a & ~REGION_MASK[i]) == REGION_BASE[i];
    endfunction

    always_comb begin
        pt_hit  = 1'b0;
        hit_idx = 2'h0;
        for (int i = NREG - 1; i >= 0; i--) begin
            if (in_region(i_ad, 2'(i))) begin
                pt_hit  = 1'b1;
                hit_idx = 2'(i);
            end
        end
    end

    assign op_hit   = (i_ad & ~OPREG_MASK) == OPREG_BASE;
    assign rd_busy  = !r.wr_dir && (r.pend || r.rd_avail);
    assign limit    = r.first ? FIRST_WAIT : NEXT_WAIT;
    assign addr_inc = r.addr + ADDR_STEP;

    always_comb begin
        n          = r;
        next_state = state;
        n.frame_act = !i_frame_n;
        // add-on side of the data register, read direction only
        if (link.addon_wr_en && r.pend && !r.wr_dir) begin
            n.data = link.addon_wr_data;
        end
        if (!link.addon_done_n && r.pend) begin
            n.pend = 1'b0;
            if (!r.wr_dir) begin
                n.rd_avail = 1'b1;
            end
        end
        case (state)
            ST_IDLE: begin
                n.devsel = 1'b0;
                n.trdy   = 1'b0;
                n.stop   = 1'b0;
                n.ad_oe  = 1'b0;
                // address phase: frame newly asserted
                if (!i_frame_n && !r.frame_act) begin
                    if (op_hit) begin
                        n.devsel   = 1'b1;
                        n.op_read  = !i_cbe_n[0];
                        next_state = ST_OPREG;
                    end else if (pt_hit) begin
                        n.devsel = 1'b1;
                        n.cnt    = 5'h00;
                        n.first  = 1'b1;
                        if (r.pend && r.wr_dir) begin
                            // registers still owed to the add-on
                            n.stop     = 1'b1;
                            next_state = ST_STOP;
                        end else if (rd_busy && hit_idx != r.region) begin
                            n.stop     = 1'b1;
                            next_state = ST_STOP;
                        end else if (rd_busy) begin
                            // same region: serve the fetched data, no reload
                            next_state = ST_RDATA;
                        end else begin
                            n.addr   = i_ad;
                            n.region = hit_idx;
                            n.wr_dir = i_cbe_n[0];
                            n.burst  = 1'b0;
                            if (i_cbe_n[0]) begin
                                n.trdy     = 1'b1;
                                next_state = ST_WDATA;
                            end else begin
                                n.pend     = 1'b1;
                                next_state = ST_RDATA;
                            end
                        end
                    end
                end
            end
            ST_WDATA: begin
                if (r.trdy) begin
                    if (!i_irdy_n) begin
                        n.data  = i_ad;
                        n.lanes = ~i_cbe_n;
                        n.pend  = 1'b1;
                        n.burst = !i_frame_n;
                        n.trdy  = 1'b0;
                        n.cnt   = 5'h00;
                        n.first = 1'b0;
                        if (i_frame_n) begin
                            n.devsel   = 1'b0;
                            next_state = ST_TURN;
                        end
                    end
                end else if (!link.addon_done_n && r.pend) begin
                    n.addr = addr_inc;
                    if (!in_region(addr_inc, r.region)) begin
                        n.stop     = 1'b1;
                        next_state = ST_STOP;
                    end else begin
                        n.trdy = 1'b1;
                    end
                end else if (r.cnt == limit - 5'h01) begin
                    n.stop     = 1'b1;
                    next_state = ST_STOP;
                end else begin
                    n.cnt = r.cnt + 5'h01;
                end
            end
            ST_RDATA: begin
                if (r.trdy) begin
                    if (!i_irdy_n) begin
                        n.trdy = 1'b0;
                        if (i_frame_n) begin
                            n.devsel   = 1'b0;
                            n.ad_oe    = 1'b0;
                            next_state = ST_TURN;
                        end else begin
                            n.addr  = addr_inc;
                            n.first = 1'b0;
                            n.cnt   = 5'h00;
                            if (!in_region(addr_inc, r.region)) begin
                                n.stop     = 1'b1;
                                next_state = ST_STOP;
                            end else begin
                                n.pend = 1'b1;
                            end
                        end
                    end
                end else if (r.rd_avail && !i_irdy_n) begin
                    n.ad       = r.data;
                    n.ad_oe    = 1'b1;
                    n.trdy     = 1'b1;
                    n.rd_avail = 1'b0;
                end else begin
                    if (r.pend && !i_irdy_n) begin
                        n.lanes = ~i_cbe_n;
                        n.burst = !i_frame_n;
                    end
                    if (r.cnt == limit - 5'h01) begin
                        n.stop     = 1'b1;
                        next_state = ST_STOP;
                    end else begin
                        n.cnt = r.cnt + 5'h01;
                    end
                end
            end
            ST_STOP: begin
                n.trdy  = 1'b0;
                n.ad_oe = 1'b0;
                if (i_frame_n) begin
                    n.devsel   = 1'b0;
                    n.stop     = 1'b0;
                    next_state = ST_TURN;
                end
            end
            ST_OPREG: begin
                if (!r.trdy) begin
                    n.ad    = {24'h00_0000, 2'h0, r.region, r.rd_avail, r.burst, r.wr_dir, r.pend};
                    n.ad_oe = r.op_read;
                    n.trdy  = 1'b1;
                end else if (!i_irdy_n) begin
                    n.trdy  = 1'b0;
                    n.ad_oe = 1'b0;
                    // one word only; longer bursts are disconnected
                    if (i_frame_n) begin
                        n.devsel   = 1'b0;
                        next_state = ST_TURN;
                    end else begin
                        n.stop     = 1'b1;
                        next_state = ST_STOP;
                    end
                end
            end
            ST_TURN: begin
                n.devsel   = 1'b0;
                n.trdy     = 1'b0;
                n.stop     = 1'b0;
                n.ad_oe    = 1'b0;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            r     <= '0;
            state <= ST_IDLE;
        end else begin
            r     <= n;
            state <= next_state;
        end
    end

    assign o_ad       = r.ad;
    assign o_ad_oe    = r.ad_oe;
    assign o_devsel_n = !r.devsel;
    assign o_trdy_n   = !r.trdy;
    assign o_stop_n   = !r.stop;
    assign o_tgt_oe   = (state != ST_IDLE);

    assign link.access_pending_n     = !r.pend;
    assign link.burst_flag_n         = !r.burst;
    assign link.region_index         = r.region;
    assign link.lane_enables_n       = ~r.lanes;
    assign link.write_direction      = r.wr_dir;
    assign link.passthru_address_reg = r.addr;
    assign link.passthru_data_reg    = r.data;
endmodule

/* pt_addon.sv */
// add-on end of the pass-through link plus its write-side fifo
// assumes the user sink and read source run on the same clock
module pt_fifo #(
    parameter int WIDTH = pt_pkg::FIFO_WIDTH,
    parameter int DEPTH = pt_pkg::FIFO_DEPTH
) (
    input  wire logic             i_clock,     // clock
    input  wire logic             i_rstn,      // async reset, active low
    input  wire logic             i_in_valid,  // write side valid
    output logic                  o_in_ready,  // not full
    input  wire logic [WIDTH-1:0] i_in_data,   // write data
    output logic                  o_out_valid, // not empty
    input  wire logic             i_out_ready, // drain side ready
    output logic      [WIDTH-1:0] o_out_data   // head word
);
    // depth must be a power of two: pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign o_in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign o_out_valid = wr_ptr != rd_ptr;
    assign o_out_data  = mem[rd_ptr[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end
endmodule

module pt_addon (
    input  wire logic        i_clock,    // same clock as the port
    input  wire logic        i_rstn,     // async reset, active low
    pt_link_if.addon         link,       // add-on link
    output logic             o_wr_valid, // write word available
    output logic      [31:0] o_wr_addr,  // its bus address
    output logic      [31:0] o_wr_data,  // its data
    input  wire logic        i_wr_ready, // sink takes word
    output logic             o_rd_req,   // read data wanted
    output logic      [31:0] o_rd_addr,  // address wanted
    input  wire logic        i_rd_valid, // source offers data
    input  wire logic [31:0] i_rd_data,  // read data
    output logic             o_rd_ready  // source word taken
);
    import pt_pkg::*;

    addon_state_e state;
    addon_state_e next_state;
    logic [31:0]  rd_word;
    logic [31:0]  next_rd_word;
    logic         push;
    logic         fifo_ready;
    logic [63:0]  fifo_out;
    logic         pending;

    assign pending = !link.access_pending_n && state == AS_IDLE;

    always_comb begin
        next_state   = state;
        next_rd_word = rd_word;
        push         = 1'b0;
        o_rd_ready   = 1'b0;
        case (state)
            AS_IDLE: begin
                if (!link.access_pending_n && link.write_direction) begin
                    // full fifo holds done back, stalling the bus side
                    push = 1'b1;
                    if (fifo_ready) begin
                        next_state = AS_DONE;
                    end
                end else if (!link.access_pending_n && i_rd_valid) begin
                    o_rd_ready   = 1'b1;
                    next_rd_word = i_rd_data;
                    next_state   = AS_WRITE;
                end
            end
            AS_WRITE: begin
                next_state = AS_DONE;
            end
            AS_DONE: begin
                next_state = AS_IDLE;
            end
            default: begin
                next_state = AS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state   <= AS_IDLE;
            rd_word <= 32'h0000_0000;
        end else begin
            state   <= next_state;
            rd_word <= next_rd_word;
        end
    end

    assign link.addon_wr_en   = state == AS_WRITE;
    assign link.addon_wr_data = rd_word;
    assign link.addon_done_n  = state != AS_DONE;
    assign o_rd_req           = pending && !link.write_direction;
    assign o_rd_addr          = link.passthru_address_reg;
    assign o_wr_addr          = fifo_out[63:32];
    assign o_wr_data          = fifo_out[31:0];

    pt_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_rstn      (i_rstn),
        .i_in_valid  (push),
        .o_in_ready  (fifo_ready),
        .i_in_data   ({link.passthru_address_reg, link.passthru_data_reg}),
        .o_out_valid (o_wr_valid),
        .i_out_ready (i_wr_ready),
        .o_out_data  (fifo_out)
    );
endmodule

/* pt_port_asserts.sv */
// concurrent checks on the add-on link between the port and the add-on end
// assumes one clock domain; instantiated beside the link interface
module pt_port_asserts (
    input wire logic        i_clock,              // clock
    input wire logic        i_rstn,               // async reset, active low
    input wire logic        access_pending_n,     // access pending, low
    input wire logic        burst_flag_n,         // burst, low
    input wire logic [1:0]  region_index,         // decoded region
    input wire logic [3:0]  lane_enables_n,       // lanes, low
    input wire logic        write_direction,      // bus write
    input wire logic [31:0] passthru_address_reg, // address register
    input wire logic [31:0] passthru_data_reg,    // data register
    input wire logic        addon_wr_en,          // add-on loads data
    input wire logic [31:0] addon_wr_data,        // value loaded
    input wire logic        addon_done_n          // completion, low
);
    timeunit 1ns;
    timeprecision 1ns;
    import pt_pkg::*;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    a_reset_idle: assert property ($rose(i_rstn) |-> access_pending_n && burst_flag_n && lane_enables_n == 4'hf)
        else $error("link status not idle after reset");
    a_done_ends_access: assert property (!access_pending_n && !addon_done_n |=> access_pending_n)
        else $error("pending not cleared by completion");
    a_pending_holds_addr: assert property (!access_pending_n && addon_done_n
        |=> $stable(passthru_address_reg) && $stable(region_index) && $stable(write_direction))
        else $error("status moved while access pending");
    a_write_holds_data: assert property (!access_pending_n && write_direction && addon_done_n
        |=> $stable(passthru_data_reg))
        else $error("write data changed before completion");
    a_load_on_read: assert property (addon_wr_en |-> !access_pending_n && !write_direction)
        else $error("data load outside pending read");
    a_load_value: assert property (addon_wr_en |=> passthru_data_reg == $past(addon_wr_data))
        else $error("data register missed add-on value");
    a_done_after_load: assert property (addon_wr_en |=> !addon_done_n)
        else $error("no completion after data load");
    a_done_one_cycle: assert property (!addon_done_n |=> addon_done_n)
        else $error("completion longer than one cycle");
    a_done_when_pending: assert property (!addon_done_n |-> !access_pending_n)
        else $error("completion without pending access");
endmodule

/* tb_pci_target_passthru_port.sv */
// bench joining the port and the add-on end through the link interface
// acts as bus initiator, add-on read source and write sink
module tb_pci_target_passthru_port;
    timeunit 1ns;
    timeprecision 1ns;
    import pt_pkg::*;

    logic        i_clock, i_rstn, frame_n, irdy_n, wr_ready, rd_valid, rty;
    logic        o_ad_oe, o_devsel_n, o_trdy_n, o_stop_n, o_tgt_oe, o_wr_valid, o_rd_req, o_rd_ready;
    logic [31:0] ad, rd_data, o_ad, o_wr_addr, o_wr_data, o_rd_addr, exp_stat;
    logic [3:0]  cbe_n;
    int          failures, compares, cycles, rd_delay, rd_cnt, got;
    logic [31:0] exp_q[$];

    pt_link_if i_pt_link_if ();
    pt_port i_pt_port (.i_clock(i_clock), .i_rstn(i_rstn), .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_ad(ad),
        .i_cbe_n(cbe_n), .o_ad(o_ad), .o_ad_oe(o_ad_oe), .o_devsel_n(o_devsel_n), .o_trdy_n(o_trdy_n),
        .o_stop_n(o_stop_n), .o_tgt_oe(o_tgt_oe), .link(i_pt_link_if.device));
    pt_addon i_pt_addon (.i_clock(i_clock), .i_rstn(i_rstn), .link(i_pt_link_if.addon), .o_wr_valid(o_wr_valid),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ready(wr_ready), .o_rd_req(o_rd_req),
        .o_rd_addr(o_rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_ready(o_rd_ready));
    pt_port_asserts i_pt_port_asserts (.i_clock(i_clock), .i_rstn(i_rstn),
        .access_pending_n(i_pt_link_if.access_pending_n), .burst_flag_n(i_pt_link_if.burst_flag_n),
        .region_index(i_pt_link_if.region_index), .lane_enables_n(i_pt_link_if.lane_enables_n),
        .write_direction(i_pt_link_if.write_direction), .passthru_address_reg(i_pt_link_if.passthru_address_reg),
        .passthru_data_reg(i_pt_link_if.passthru_data_reg), .addon_wr_en(i_pt_link_if.addon_wr_en),
        .addon_wr_data(i_pt_link_if.addon_wr_data), .addon_done_n(i_pt_link_if.addon_done_n));
    wire         pend_n    = i_pt_link_if.access_pending_n;
    wire         burst_n   = i_pt_link_if.burst_flag_n;
    wire  [31:0] link_addr = i_pt_link_if.passthru_address_reg;

    // data tied to its address so any word can be checked where it lands
    function automatic logic [31:0] dat(input logic [31:0] a);
        return a ^ 32'h5ac3_0000;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic expect_xfer(input string name, input int g, input logic r);
        check("data phases", 32'(got), 32'(g));
        check("retry", {31'h0, rty}, {31'h0, r});
        $display("test %s ended", name);
    endtask

    // initiator: n data phases, stops on retry or after 60 idle cycles
    task automatic bus(input logic [31:0] a, input logic wr, input int n);
        int w;
        got = 0;
        rty = 1'b0;
        w   = 0;
        @(posedge i_clock);
        frame_n <= 1'b0;
        ad      <= a;
        cbe_n   <= {3'b011, wr};
        @(posedge i_clock);
        frame_n <= (n == 1);
        irdy_n  <= 1'b0;
        ad      <= dat(a);
        cbe_n   <= 4'h0;
        while (got < n && !rty && w < 60) begin
            @(negedge i_clock);
            w++;
            if (!o_stop_n) begin
                check("retry claim", {30'h0, o_devsel_n, o_tgt_oe}, 32'h1);
                rty = 1'b1;
            end else if (!o_trdy_n) begin
                check("claim", {30'h0, o_devsel_n, o_tgt_oe}, 32'h1);
                if (!wr) check("ad drive", {31'h0, o_ad_oe}, 32'h1);
                if (!wr && a[31:28] == 4'h1) check("read data", o_ad, dat(a + 32'(got * 4)));
                if (!wr && a[31:28] == 4'h2) check("status", o_ad, exp_stat);
                if (wr) exp_q.push_back(a + 32'(got * 4));
                got++;
                w = 0;
                @(posedge i_clock);
                frame_n <= (got >= n - 1);
                irdy_n  <= (got >= n);
                ad      <= dat(a + 32'(got * 4));
            end
        end
        @(posedge i_clock);
        frame_n <= 1'b1;
        irdy_n  <= 1'b1;
        repeat (2) @(posedge i_clock);
    endtask

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    // add-on read source with a settable delay, and write sink
    always @(posedge i_clock) begin
        if (o_rd_ready || !o_rd_req) begin
            rd_valid <= 1'b0;
            rd_cnt   <= 0;
        end else begin
            rd_cnt   <= rd_cnt + 1;
            rd_valid <= (rd_cnt >= rd_delay);
        end
        rd_data <= dat(o_rd_addr);
        if (o_wr_valid && wr_ready) begin
            check("sink address", o_wr_addr, exp_q.size() > 0 ? exp_q.pop_front() : 32'h0);
            check("sink data", o_wr_data, dat(o_wr_addr));
        end
        if (!pend_n && i_pt_link_if.write_direction) begin
            check("region", {30'h0, i_pt_link_if.region_index}, {30'h0, link_addr[13:12]});
            check("lanes", {28'h0, i_pt_link_if.lane_enables_n}, 32'h0);
            // only the 4-phase region 3 burst writes here; its last phase runs with frame high
            if (i_pt_link_if.region_index == 2'h3) begin
                check("burst", {31'h0, burst_n}, {31'h0, link_addr[3:0] == 4'hc});
            end
        end
    end

    initial begin
        i_rstn   = 1'b0;
        frame_n  = 1'b1;
        irdy_n   = 1'b1;
        ad       = 32'h0;
        cbe_n    = 4'hf;
        wr_ready = 1'b1;
        rd_valid = 1'b0;
        rd_data  = 32'h0;
        rd_cnt   = 0;
        rd_delay = 2;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(negedge i_clock);
        check("idle", {27'h0, pend_n, burst_n, o_devsel_n, o_trdy_n, o_stop_n}, 32'h1f);
        bus(REGION_BASE[1] + 32'h8, 1'b1, 1);
        expect_xfer("single write", 1, 1'b0);
        bus(32'h3000_0000, 1'b1, 1);
        expect_xfer("unclaimed", 0, 1'b0);
        bus(REGION_BASE[3], 1'b1, 4);
        expect_xfer("burst write", 4, 1'b0);
        bus(REGION_BASE[0] + 32'hff8, 1'b1, 4);
        expect_xfer("region end", 2, 1'b1);
        bus(REGION_BASE[2] + 32'h10, 1'b0, 1);
        expect_xfer("single read", 1, 1'b0);
        bus(REGION_BASE[2] + 32'h20, 1'b0, 3);
        expect_xfer("burst read", 3, 1'b0);
        rd_delay = 7;
        bus(REGION_BASE[3] + 32'h80, 1'b0, 3);
        expect_xfer("later phase wait", 1, 1'b1);
        repeat (30) @(posedge i_clock);
        bus(REGION_BASE[3] + 32'h84, 1'b0, 1);
        expect_xfer("same address back", 1, 1'b0);
        rd_delay = 36;
        bus(REGION_BASE[1] + 32'h40, 1'b0, 1);
        expect_xfer("first phase wait", 0, 1'b1);
        bus(REGION_BASE[0], 1'b0, 1);
        expect_xfer("other region", 0, 1'b1);
        exp_stat = 32'h11; // region 1 read still pending, no data back yet
        bus(OPREG_BASE, 1'b0, 1);
        expect_xfer("op register", 1, 1'b0);
        bus(REGION_BASE[1] + 32'h40, 1'b0, 1);
        expect_xfer("waited retry", 1, 1'b0);
        rd_delay = 2;
        wr_ready <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            bus(REGION_BASE[2] + 32'(i * 4), 1'b1, 1);
            expect_xfer("fill", 1, 1'b0);
        end
        bus(REGION_BASE[2] + 32'h100, 1'b1, 1);
        expect_xfer("write busy", 0, 1'b1);
        wr_ready <= 1'b1;
        repeat (40) @(posedge i_clock);
        check("undelivered", 32'(exp_q.size()), 32'h0);
        test_done();
    end
endmodule
